// ===== inc/wdds_consts.vh
// timing constants for the watchdog disable sequencer
`ifndef WDDS_CONSTS_VH
`define WDDS_CONSTS_VH
`define WDDS_CLK_MHZ 250
`define WDDS_TRIG_WIN_MS 48
`define WDDS_IGN_WIN_MS 16
`define WDDS_LOW_PULSE_MS 8
`define WDDS_FILT_MAX_US 500
`define WDDS_FILT_MIN_US 100
`define WDDS_TRIG_WIN_CYC (`WDDS_TRIG_WIN_MS * 1000 * `WDDS_CLK_MHZ)
`define WDDS_IGN_WIN_CYC (`WDDS_IGN_WIN_MS * 1000 * `WDDS_CLK_MHZ)
`define WDDS_LOW_PULSE_CYC (`WDDS_LOW_PULSE_MS * 1000 * `WDDS_CLK_MHZ)
`define WDDS_FILT_CYC (`WDDS_FILT_MAX_US * `WDDS_CLK_MHZ)
`endif

// ===== rtl/wdds_sequencer.v
// watchdog state sequencer with trigger window, low pulse and filtered disable
//
// Overview of operation
// - fixed 48 ms trigger window after ignore
// - disable level on disable_level_window input disables watchdog
// - enter disable after level held full filter
// - leaving disable restarts with ignore window
// - exit from disable uses same filter
// - missed trigger drives combined output low
// - missed trigger low followed by ignore window
// - output stays high while disabled if high
// - disable during low finishes full low pulse
// - short disable truncates low, then ignore
// - scenarios A-C assume long disable interval
// - falling trigger edge restarts trigger window
// - filter time between 100 and 500 us
// - output low pulse nominally 8 ms
`timescale 1ns/1ns
`include "wdds_consts.vh"
module wdds_sequencer #(
  parameter integer TRIG_CYC = `WDDS_TRIG_WIN_CYC,
  parameter integer IGN_CYC = `WDDS_IGN_WIN_CYC,
  parameter integer LOW_CYC = `WDDS_LOW_PULSE_CYC,
  parameter integer FILT_CYC = `WDDS_FILT_CYC
) (
  input wire clock,
  input wire rst_n,
  input wire watchdog_trigger_input,
  input wire disable_level_window,
  output reg reset_watchdog_out_n,
  output reg out_oe,
  output reg wd_disabled
);
  // one-hot states
  localparam [3:0] S_IGN = 4'h1;
  localparam [3:0] S_TRIG = 4'h2;
  localparam [3:0] S_LOW = 4'h4;
  localparam [3:0] S_DIS = 4'h8;

  reg trig_s1_q; // synchroniser first stage
  reg trig_s2_q; // synchronised trigger
  reg trig_s3_q; // delayed for edge detect
  reg dis_s1_q; // synchroniser first stage
  reg dis_s2_q; // synchronised disable level
  reg [3:0] state_q; // sequencer state
  reg [31:0] cnt_q; // window counter
  reg [31:0] filt_q; // filter counter
  reg dis_q; // filtered disable state
  reg low_pend_q; // low pulse still to finish while disabled
  reg [31:0] low_cnt_q; // low pulse counter during disable
  wire fall; // trigger falling edge
  wire filt_done; // level held long enough

  // edge decode on synchronised trigger; no dead time, fall is taken straight from the sync
  assign fall = trig_s3_q & ~trig_s2_q;
  assign filt_done = (filt_q == FILT_CYC - 1);

  // two flop synchronisers and edge register
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      dis_s1_q <= 1'b0;
      dis_s2_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= watchdog_trigger_input;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      dis_s1_q <= disable_level_window;
      dis_s2_q <= dis_s1_q;
    end
  end

  // filter: level must differ from filtered state continuously
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_q <= 32'h0;
      dis_q <= 1'b0;
    end
    else if (dis_s2_q != dis_q)
    begin
      if (filt_done)
      begin
        dis_q <= dis_s2_q;
        filt_q <= 32'h0;
      end
      else
        filt_q <= filt_q + 32'h1;
    end
    else
      filt_q <= 32'h0; // excursion too short, restart
  end

  // main sequencer
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IGN;
      cnt_q <= 32'h0;
      low_pend_q <= 1'b0;
      low_cnt_q <= 32'h0;
      reset_watchdog_out_n <= 1'b1;
      out_oe <= 1'b0;
      wd_disabled <= 1'b0;
    end
    else
    begin
      wd_disabled <= dis_q;
      case (state_q)
        // ignore window: no trigger needed
        S_IGN:
        begin
          if (dis_q)
          begin
            state_q <= S_DIS;
            cnt_q <= 32'h0;
          end
          else if (cnt_q == IGN_CYC - 1)
          begin
            state_q <= S_TRIG;
            cnt_q <= 32'h0;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
        // trigger window: falling edge restarts
        S_TRIG:
        begin
          if (dis_q)
          begin
            state_q <= S_DIS;
            cnt_q <= 32'h0;
          end
          else if (fall)
            cnt_q <= 32'h0;
          else if (cnt_q == TRIG_CYC - 1)
          begin
            state_q <= S_LOW;
            cnt_q <= 32'h0;
            reset_watchdog_out_n <= 1'b0;
            out_oe <= 1'b1;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
        // output low pulse
        S_LOW:
        begin
          if (dis_q)
          begin
            state_q <= S_DIS; // low pulse continues under disable
            low_cnt_q <= cnt_q + 32'h1;
            cnt_q <= 32'h0;
            // pulse may end on this very edge; avoid one extra cycle low
            if (cnt_q == LOW_CYC - 1)
            begin
              low_pend_q <= 1'b0;
              reset_watchdog_out_n <= 1'b1;
              out_oe <= 1'b0;
            end
            else
              low_pend_q <= 1'b1;
          end
          else if (cnt_q == LOW_CYC - 1)
          begin
            state_q <= S_IGN;
            cnt_q <= 32'h0;
            reset_watchdog_out_n <= 1'b1;
            out_oe <= 1'b0;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
        // disabled: finish pending low pulse, then stay high
        S_DIS:
        begin
          if (!dis_q)
          begin
            state_q <= S_IGN;
            cnt_q <= 32'h0;
            low_pend_q <= 1'b0;
            reset_watchdog_out_n <= 1'b1;
            out_oe <= 1'b0;
          end
          else if (low_pend_q)
          begin
            if (low_cnt_q >= LOW_CYC - 1)
            begin
              low_pend_q <= 1'b0;
              reset_watchdog_out_n <= 1'b1;
              out_oe <= 1'b0;
            end
            else
              low_cnt_q <= low_cnt_q + 32'h1;
          end
          else
          begin
            reset_watchdog_out_n <= 1'b1;
            out_oe <= 1'b0;
          end
        end
        default:
        begin
          state_q <= S_IGN;
          cnt_q <= 32'h0;
        end
      endcase
    end
  end
endmodule // wdds_sequencer

// ===== test/wdds_chk.sv
// port assertions for the watchdog sequencer
`timescale 1ns/1ns
module wdds_chk (
  input wire clock,
  input wire rst_n,
  input wire watchdog_trigger_input,
  input wire disable_level_window,
  input wire reset_watchdog_out_n,
  input wire out_oe,
  input wire wd_disabled
);
  wire o = reset_watchdog_out_n;
  wire d = wd_disabled;
  wire l = disable_level_window;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_oe; out_oe == !o; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_in; $rose(d) |-> $past(l, 4) && $past(l, 6); endproperty
  a_in: assert property (p_in) else $error("in");
  property p_ex; $fell(d) |-> !$past(l, 4) && !$past(l, 6); endproperty
  a_ex: assert property (p_ex) else $error("ex");
  property p_hi; d && o |=> o; endproperty
  a_hi: assert property (p_hi) else $error("hi");
  // bench runs a 24-cycle low pulse
  property p_lo; $fell(o) |-> ##24 o; endproperty
  a_lo: assert property (p_lo) else $error("lo");
  property p_ig; $rose(o) |-> o [*8]; endproperty
  a_ig: assert property (p_ig) else $error("ig");
  property p_nd; $fell(o) |-> !$past(d); endproperty
  a_nd: assert property (p_nd) else $error("nd");
  property p_tr; $fell(o) |-> !($past(watchdog_trigger_input, 9) && !$past(watchdog_trigger_input, 8)); endproperty
  a_tr: assert property (p_tr) else $error("tr");
  cover property ($rose(d));
  cover property ($fell(d));
  cover property ($fell(o));
  c_dlow: cover property (d && !o);
endmodule // wdds_chk
bind wdds_sequencer wdds_chk u_chk (.clock, .rst_n, .watchdog_trigger_input, .disable_level_window,
  .reset_watchdog_out_n, .out_oe, .wd_disabled);

// ===== test/wdds_mcu.sv
// controller model driving the trigger pin
`timescale 1ns/1ns
module wdds_mcu (
  input wire clock,
  input wire serve,
  output reg trig = 1'b0
);
  reg [3:0] cnt_q = 4'h0;
  // one falling edge each 16 cycles, pulled low while idle
  always @(negedge clock)
  begin
    cnt_q <= cnt_q + 4'h1;
    trig <= serve & cnt_q[3];
  end
endmodule // wdds_mcu

// ===== test/wdds_tb.sv
// self-checking bench for the watchdog sequencer
`timescale 1ns/1ns
`define CHK(s,e,a) begin checked++; if ((a)!==(e)) begin miscompares++; $display("[ERR] %s %h %h",s,e,a); end end
module testbench;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg serve = 1'b0;
  reg lvl = 1'b0;
  wire trig, out_n, oe, dis;
  int miscompares = 0;
  int checked = 0;
  int n, len;
  // shortened windows; the checker's delays assume these
  localparam int TRIG = 40;
  localparam int IGN = 16;
  localparam int LOW = 24;
  localparam int FILT = 4;
  always #2 clock = !clock;
  wdds_mcu mcu (.clock, .serve, .trig);
  wdds_sequencer #(.TRIG_CYC(TRIG), .IGN_CYC(IGN), .LOW_CYC(LOW), .FILT_CYC(FILT)) DUT (.clock, .rst_n,
    .watchdog_trigger_input(trig), .disable_level_window(lvl), .reset_watchdog_out_n(out_n), .out_oe(oe),
    .wd_disabled(dis));
  task print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // wait for a low pulse, set the level, time the pulse
  task low_len(input bit g);
    for (n = 0; out_n !== 1'b0 && n < 200; n++) @(negedge clock);
    lvl = g;
    for (len = 0; out_n === 1'b0 && len < 50; len++) @(negedge clock);
  endtask
  // missed trigger, then steady serving
  task t_miss;
    low_len(0);
    `CHK("first", IGN + TRIG, n)
    `CHK("low", LOW, len)
    serve = 1;
    repeat (150) begin @(negedge clock); `CHK("srv", 1'b1, out_n) end
    $display("t_miss done");
  endtask
  // filtered entry and exit of disable
  task t_dis;
    lvl = 1;
    repeat (2) @(negedge clock);
    lvl = 0;
    repeat (10) @(negedge clock);
    `CHK("glitch", 1'b0, dis)
    lvl = 1;
    repeat (20) @(negedge clock);
    `CHK("dis", 1'b1, dis)
    serve = 0;
    repeat (100) begin @(negedge clock); `CHK("held", 1'b1, out_n) end
    lvl = 0;
    repeat (2) @(negedge clock);
    lvl = 1;
    repeat (10) @(negedge clock);
    `CHK("stay", 1'b1, dis)
    lvl = 0;
    repeat (10) @(negedge clock);
    `CHK("exit", 1'b0, dis)
    low_len(0);
    `CHK("ign", 1'b1, n >= 40)
    $display("t_dis done");
  endtask
  // disable taken during the low pulse
  task t_dlow;
    low_len(1);
    `CHK("gap", IGN + TRIG, n)
    `CHK("ldis", LOW, len)
    repeat (20) @(negedge clock);
    `CHK("rel", 1'b1, out_n)
    lvl = 0;
    $display("t_dlow done");
  endtask
  // disable shorter than the low pulse truncates it
  task t_short;
    for (n = 0; out_n !== 1'b0 && n < 200; n++) @(negedge clock);
    lvl = 1;
    repeat (8) @(negedge clock);
    lvl = 0;
    for (len = 8; out_n === 1'b0 && len < 50; len++) @(negedge clock);
    `CHK("short", 1'b1, len > 8 && len < LOW)
    for (n = 0; out_n !== 1'b0 && n < 200; n++) @(negedge clock);
    `CHK("resume", IGN + TRIG, n)
    $display("t_short done");
  endtask
  // disable taken in the ignore window after a low pulse
  task t_cign;
    low_len(0);
    `CHK("clow", LOW, len)
    lvl = 1;
    repeat (30) begin @(negedge clock); `CHK("chi", 1'b1, out_n) end
    `CHK("cdis", 1'b1, dis)
    lvl = 0;
    low_len(0);
    `CHK("cgap", 1'b1, n > IGN + TRIG + FILT && n < IGN + TRIG + FILT + 8)
    $display("t_cign done");
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    `CHK("rst", 1'b1, out_n & !oe & !dis)
    rst_n = 1;
    t_miss;
    t_dis;
    t_dlow;
    t_short;
    t_cign;
    print_verdict;
  end
  initial
  begin
    // about ten times the expected run
    #40000;
    miscompares++;
    print_verdict;
  end
endmodule // testbench
